// [rtl/asqbc_regs.vh]
`ifndef ASQBC_REGS_VH
`define ASQBC_REGS_VH
// geometry
`define ASQBC_DIES 4
`define ASQBC_AW 19
`define ASQBC_WORDS 524288
`define ASQBC_DW 32
// timing figures in ns at a 10 ns clock
`define ASQBC_CLK_NS 10
`define ASQBC_ADDR_TO_DATA_NS 25
`define ASQBC_MIN_CYCLE_NS 25
`define ASQBC_STROBE_LOW_NS 20
`define ASQBC_STROBE_TO_FLOAT_NS 10
`define ASQBC_WRITE_RECOVER_NS 5
// cycle counts: every time, least or longest, rounds up to whole clocks
`define ASQBC_CEIL(t) (((t) + `ASQBC_CLK_NS - 1) / `ASQBC_CLK_NS)
`define ASQBC_READ_CYC `ASQBC_CEIL(`ASQBC_ADDR_TO_DATA_NS)
`define ASQBC_CYCLE_CYC `ASQBC_CEIL(`ASQBC_MIN_CYCLE_NS)
`define ASQBC_STROBE_CYC `ASQBC_CEIL(`ASQBC_STROBE_LOW_NS)
`define ASQBC_FLOAT_CYC `ASQBC_CEIL(`ASQBC_STROBE_TO_FLOAT_NS)
`define ASQBC_RECOVER_CYC `ASQBC_CEIL(`ASQBC_WRITE_RECOVER_NS)
`endif

// [rtl/asqbc_timer.v]
`timescale 1ns/100ps
// down counter that marks when a loaded count has run out
module asqbc_timer (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// control
	input wire load,
	input wire [3:0] count,
	// status
	output wire done
);
	reg [3:0] left;

	// count down to zero after a load
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			left <= 4'h0;
		end else if (load) begin
			left <= count;
		end else if (left != 4'h0) begin
			left <= left - 4'h1;
		end
	end

	// done depends on the register left alone, so a load that is itself
	// decided from done cannot close a combinational loop
	assign done = (left == 4'h0);
endmodule

// [rtl/asqbc_ctrl.v]
`timescale 1ns/100ps
`include "asqbc_regs.vh"
// Function
// - A die with select and strobe both low stores its byte at the addressed word.
// - The controller drives select and strobe of each chosen die together to make 8 to 32 bit accesses.
// - Address may change no faster than once per minimum cycle time while reading.
// - During a select driven read address, enable and strobe stay steady for the whole cycle.
// - A strobe ended write holds the strobe low for the strobe low width with select still low.
// - The controller waits the strobe to float delay after lowering strobe before driving data.
// - A select ended write keeps select low for the select pulse width.
module asqbc_ctrl (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// user request
	input wire req_valid,
	input wire req_write,
	input wire [3:0] req_lanes,
	input wire [18:0] req_addr,
	input wire [31:0] req_wdata,
	output reg req_ready,
	// user answer
	output reg rsp_valid,
	output reg [31:0] rsp_rdata,
	// memory pins
	output reg [18:0] mem_addr,
	output reg [3:0] die_select_n,
	output reg [3:0] die_write_strobe_n,
	output reg mem_oe_n,
	input wire [31:0] die_byte_lines_in,
	output reg [31:0] die_byte_lines_out,
	output reg [3:0] die_byte_lines_oe
);
	// one-hot phase codes
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_READ = 5'h02;
	localparam [4:0] ST_FLOAT = 5'h04;
	localparam [4:0] ST_WRITE = 5'h08;
	localparam [4:0] ST_RECOVER = 5'h10;

	// phase lengths in clock cycles, worked out as integers first
	localparam integer READ_I = `ASQBC_READ_CYC;
	localparam integer CYCLE_I = `ASQBC_CYCLE_CYC;
	localparam integer FLOAT_I = `ASQBC_FLOAT_CYC;
	localparam integer STROBE_I = `ASQBC_STROBE_CYC;
	localparam integer RECOVER_I = `ASQBC_RECOVER_CYC;
	// the timer holds four bits, so each count is cut to that width
	localparam [3:0] READ_CNT = READ_I[3:0];
	localparam [3:0] CYCLE_CNT = CYCLE_I[3:0];
	localparam [3:0] FLOAT_CNT = FLOAT_I[3:0];
	localparam [3:0] STROBE_CNT = STROBE_I[3:0];
	localparam [3:0] RECOVER_CNT = RECOVER_I[3:0];
	// a read waits out both the access delay and the cycle time
	localparam [3:0] READ_WAIT = (READ_CNT > CYCLE_CNT) ? READ_CNT :
		CYCLE_CNT;

	// phase, latched request and timer control
	reg [4:0] state;
	reg [3:0] lanes;
	reg [31:0] wdata;
	reg tload;
	reg [3:0] tcount;
	wire tdone;
	// read word with the unused lanes cleared
	wire [31:0] lane_rdata;

	// one timer paces every phase of a cycle
	asqbc_timer u_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.load(tload),
		.count(tcount),
		.done(tdone)
	);

	// per lane read capture: a lane that was not selected reads as zero,
	// so a floating byte never leaks into the answer
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_lane
			assign lane_rdata[8*g+7:8*g] = lanes[g] ?
				die_byte_lines_in[8*g+7:8*g] : 8'h00;
		end
	endgenerate

	// timer load for each phase entry
	always @* begin
		tload = 1'b0;
		tcount = 4'h0;
		case (state)
			// a taken request starts the first phase
			ST_IDLE: begin
				if (req_valid && req_ready) begin
					tload = 1'b1;
					// write floats first, read waits the full access
					tcount = req_write ? FLOAT_CNT : READ_WAIT;
				end
			end

			// rest of the strobe low time once data is driven
			ST_FLOAT: begin
				if (tdone) begin
					tload = 1'b1;
					tcount = STROBE_CNT - FLOAT_CNT;
				end
			end

			// both access phases end in the same recovery gap
			ST_READ, ST_WRITE: begin
				if (tdone) begin
					tload = 1'b1;
					tcount = RECOVER_CNT;
				end
			end

			// recovery only waits for the running count
			ST_RECOVER: begin
				tload = 1'b0;
			end

			// unknown phase loads nothing
			default: begin
				tload = 1'b0;
			end
		endcase
	end

	// cycle sequencer and pin drive
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			lanes <= 4'h0;
			wdata <= 32'h00000000;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= 32'h00000000;
			mem_addr <= 19'h00000;
			die_select_n <= 4'hF;
			die_write_strobe_n <= 4'hF;
			mem_oe_n <= 1'b1;
			die_byte_lines_out <= 32'h00000000;
			die_byte_lines_oe <= 4'h0;
		end else begin
			rsp_valid <= 1'b0;
			case (state)
				// wait for a request and put it on the pins
				ST_IDLE: begin
					req_ready <= 1'b1;
					if (req_valid && req_ready) begin
						req_ready <= 1'b0;
						lanes <= req_lanes;
						wdata <= req_wdata;
						mem_addr <= req_addr;
						// select and strobe share one lane mask
						die_select_n <= ~req_lanes;
						if (req_write) begin
							// strobe low first, byte lines still floating
							die_write_strobe_n <= ~req_lanes;
							mem_oe_n <= 1'b1;
							state <= ST_FLOAT;
						end else begin
							mem_oe_n <= 1'b0;
							state <= ST_READ;
						end
					end
				end

				// hold the read pins until the access time is out
				ST_READ: begin
					// address, enable and strobe held steady
					if (tdone) begin
						rsp_rdata <= lane_rdata;
						rsp_valid <= 1'b1;
						die_select_n <= 4'hF;
						mem_oe_n <= 1'b1;
						state <= ST_RECOVER;
					end
				end

				// strobe is low, wait for the dies to let go
				ST_FLOAT: begin
					if (tdone) begin
						// dies have floated, now drive the data
						die_byte_lines_out <= wdata;
						die_byte_lines_oe <= lanes;
						state <= ST_WRITE;
					end
				end

				// data stands under the low strobe
				ST_WRITE: begin
					if (tdone) begin
						// strobe and select rise together
						die_write_strobe_n <= 4'hF;
						die_select_n <= 4'hF;
						state <= ST_RECOVER;
					end
				end

				// data held one more cycle, then the lines are freed
				ST_RECOVER: begin
					die_byte_lines_oe <= 4'h0;
					if (tdone) begin
						req_ready <= 1'b1;
						state <= ST_IDLE;
					end
				end

				// an unknown phase falls back to idle
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

// [bench/asqbc_properties.sv]
`timescale 1ns/100ps
// pin timing checks on the controller
module asqbc_props (
	// clock and reset
	input logic core_clk,
	input logic rst_n,
	// request handshake
	input logic req_valid,
	input logic req_ready,
	input logic req_write,
	input logic rsp_valid,
	// memory pins
	input logic mem_oe_n,
	input logic [18:0] mem_addr,
	input logic [3:0] die_select_n,
	input logic [3:0] die_write_strobe_n,
	input logic [3:0] die_byte_lines_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// taken reads and writes
	wire rd = req_valid && req_ready && !req_write;
	wire wr = req_valid && req_ready && req_write;
	wire [3:0] wn = die_write_strobe_n;
	property p_rsp; rd |-> ##5 rsp_valid; endproperty
	a_rsp: assert property (p_rsp) else $error("read late");
	property p_oe; rd |=> !mem_oe_n [*4]; endproperty
	a_oe: assert property (p_oe) else $error("read short");
	property p_adr; !mem_oe_n && $past(!mem_oe_n) |-> $stable(mem_addr);
	endproperty
	a_adr: assert property (p_adr) else $error("addr moved");
	property p_pair; ((~wn) & die_select_n) == 4'h0; endproperty
	a_pair: assert property (p_pair) else $error("strobe alone");
	property p_wrv; wr |=> mem_oe_n [*4]; endproperty
	a_wrv: assert property (p_wrv) else $error("oe in write");
	property p_wid; $fell(&wn) |=> !(&wn); endproperty
	a_wid: assert property (p_wid) else $error("strobe short");
	property p_flt; $fell(&wn) |-> die_byte_lines_oe == 4'h0; endproperty
	a_flt: assert property (p_flt) else $error("drove early");
	property p_cont; |die_byte_lines_oe |-> mem_oe_n; endproperty
	a_cont: assert property (p_cont) else $error("contention");
	// a new address stands for at least the minimum cycle time
	property p_gap; $changed(mem_addr) |=> $stable(mem_addr) [*2];
	endproperty
	a_gap: assert property (p_gap) else $error("addr too fast");
	c_rd: cover property (rd);
	c_wr: cover property (wr);
	c_rsp: cover property (rsp_valid);
endmodule
bind asqbc_ctrl asqbc_props u_props (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.req_valid(req_valid),
	.req_ready(req_ready),
	.req_write(req_write),
	.rsp_valid(rsp_valid),
	.mem_oe_n(mem_oe_n),
	.mem_addr(mem_addr),
	.die_select_n(die_select_n),
	.die_write_strobe_n(die_write_strobe_n),
	.die_byte_lines_oe(die_byte_lines_oe)
);

// [bench/asqbc_mem_model.sv]
`timescale 1ns/100ps
// four byte dies on a shared address and output enable
module asqbc_mem_model (
	// shared pins
	input logic [18:0] mem_addr,
	input logic mem_oe_n,
	// per die controls
	input logic [3:0] die_select_n,
	input logic [3:0] die_write_strobe_n,
	// byte lines: level seen, value and enable driven by the dies
	input logic [31:0] bus,
	output logic [31:0] dq,
	output logic [3:0] en
);
	logic [7:0] m [4][524288];
	wire [23:0] now = {mem_addr, die_select_n, mem_oe_n};
	wire [23:0] old;
	// data settles only once the last input held still 25 ns
	assign #25 old = now;
	initial foreach (m[i, j]) m[i][j] = 8'h00;
	for (genvar i = 0; i < 4; i++) begin : g_die
		wire s = !die_select_n[i];
		assign en[i] = s && !mem_oe_n && die_write_strobe_n[i];
		assign dq[8*i+:8] = old === now ? m[i][mem_addr] : ~m[i][mem_addr];
		// store while select and strobe are low
		always @* if (s && !die_write_strobe_n[i])
			m[i][mem_addr] = bus[8*i+:8];
	end
endmodule

// [bench/test_async_sram_quad_byte_module.sv]
`timescale 1ns/100ps
// random writes or reads, each followed by a masked read-back
module test_async_sram_quad_byte_module;
	logic core_clk = 0, rst_n = 0, req_valid = 0, req_write = 0;
	logic [3:0] req_lanes = 0;
	logic [18:0] req_addr = 0, mem_addr;
	logic [31:0] req_wdata = 0, last = 0, st = 4;
	logic [31:0] rsp_rdata, die_byte_lines_out, bus, dq;
	logic req_ready, rsp_valid, mem_oe_n;
	logic [3:0] die_select_n, die_write_strobe_n, die_byte_lines_oe, en;
	logic [31:0] sh [int];
	int n_mismatch = 0, checked = 0;
	asqbc_ctrl dut (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.req_valid(req_valid),
		.req_write(req_write),
		.req_lanes(req_lanes),
		.req_addr(req_addr),
		.req_wdata(req_wdata),
		.req_ready(req_ready),
		.rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata),
		.mem_addr(mem_addr),
		.die_select_n(die_select_n),
		.die_write_strobe_n(die_write_strobe_n),
		.mem_oe_n(mem_oe_n),
		.die_byte_lines_in(bus),
		.die_byte_lines_out(die_byte_lines_out),
		.die_byte_lines_oe(die_byte_lines_oe)
	);
	asqbc_mem_model mdl (
		.mem_addr(mem_addr),
		.mem_oe_n(mem_oe_n),
		.die_select_n(die_select_n),
		.die_write_strobe_n(die_write_strobe_n),
		.bus(bus),
		.dq(dq),
		.en(en)
	);
	// bus level: a released lane shows the inverse of its last value
	always @* for (int i = 0; i < 4; i++)
		bus[8*i+:8] = die_byte_lines_oe[i] ? die_byte_lines_out[8*i+:8] :
			en[i] ? dq[8*i+:8] : ~last[8*i+:8];
	always @(posedge core_clk) last <= bus;
	initial forever #5 core_clk = ~core_clk;
	function logic [31:0] rnd();
		st ^= st << 13;
		st ^= st >> 17;
		st ^= st << 5;
		return st;
	endfunction
	function logic [31:0] msk(input logic [3:0] l);
		for (int i = 0; i < 4; i++) msk[8*i+:8] = {8{l[i]}};
	endfunction
	task chk(input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task op(input logic w, input logic [3:0] l, input logic [18:0] a,
		input logic [31:0] d);
		logic [31:0] e, o;
		e = msk(l);
		o = sh.exists(a) ? sh[a] : 32'h0;
		req_write = w;
		req_lanes = l;
		req_addr = a;
		req_wdata = d;
		req_valid = 1;
		while (req_ready !== 1'b1) @(negedge core_clk);
		@(negedge core_clk);
		req_valid = 0;
		if (w) begin
			sh[a] = (o & ~e) | (d & e);
			// let an edge pass so valid is never lowered and raised at once
			@(negedge core_clk);
		end else begin
			while (rsp_valid !== 1'b1) @(negedge core_clk);
			chk(rsp_rdata, o & e);
		end
	endtask
	// the controller never drives a lane a die is driving
	always @(negedge core_clk) if (rst_n)
		chk(32'(die_byte_lines_oe & en), 32'h0);
	initial begin
		#30000;
		n_mismatch++;
		complete_run;
	end
	initial begin
		logic [18:0] a;
		repeat (2) @(negedge core_clk);
		rst_n = 1;
		@(negedge core_clk);
		chk(32'(die_select_n), 32'hF);
		op(1, 4'hF, 19'h7FFFF, 32'hA5C31E0F);
		op(1, 4'h0, 19'h7FFFF, 32'h0);
		op(0, 4'hF, 19'h7FFFF, 32'h0);
		$display("test corner done");
		for (int t = 0; t < 40; t++) begin
			a = 19'(rnd()) & 19'h40007;
			op(1'(rnd()), 4'(rnd()), a, rnd());
			op(0, 4'(rnd()), a, 32'h0);
			$display("test %0d done", t);
		end
		complete_run;
	end
endmodule
